// *** sfce_top.sv ***
// Contract
// - lrv_select_bit 0: supply, regulator-low (bit 4), operation-fail (bit 5) flags.
// - lrv_select_bit 1: bit 4 program failure, bit 5 erase failure.
// - 50h clears status bits 3, 4, 5 and returns to read-array.
// - 96h arms config load; next write loads bits 0-7 and 24-31; the load mask takes only 0-7, 24-25 and 28-31.
// - low load_burst_address_n on clock latches address, samples read select.
// - output_enable_n low on clock drives data on x32 or x16 lanes.
// - address at clock 1, enable at clock 2, data valid for clock 3.
// - burst: enable low four clocks, advance low last three, four words.
// - output_valid_n low only while valid read data is driven.
// - after 90h: A1A0 00 maker, 01 part, 10 config register.
// - 70h selects status output; status refreshed every clock.
// - accept reads with address latch held low through both phases.
// - 40h/04h then data starts programming; only status reads meanwhile.
// - word_write_cycles_bit with x16 bus uses three-cycle program write.
// - asynchronous write latches on write strobe rising edge.
// - reset_powerdown_n low aborts program or erase.
// - programming only clears bits, ones leave cells, no error.
// - all-ones data after setup aborts; status only until ready.
// - erase 20h/D0h main, 02h/0Dh overlay, block to ones, status only.
// - F0h reduced power; any later command restores full power.
// - status bit 7 is 1 when ready, 0 while busy.
// - reset_powerdown_n low ends activity, ignores bus, reinit to read-array.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "sfce_map.svh"

module sfce_top
  import sfce_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic reset_powerdown_n_in,
  input wire sfce_strobes_t strobes_in,
  input wire logic [16:0] addr_in,
  input wire logic addr_half_in,
  input wire logic word_mode_in,
  input wire logic vpp_ok_in,
  input wire logic regulator_low_n_in,
  input wire logic [31:0] dq_in,
  output logic [31:0] dq_out,
  output logic [31:0] dq_oe_out,
  output logic output_valid_n_out,
  output logic ready_busy_pin_out,
  output logic reduced_power_out,
  output logic [17:0] array_rd_addr_out,
  input wire logic [31:0] array_rdata_in,
  output sfce_array_req_t array_req_out
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [4:0] burst_mask(input logic [1:0] code);
    unique case (code)
      2'b00: burst_mask = 5'h03;
      2'b01: burst_mask = 5'h07;
      2'b10: burst_mask = 5'h0f;
      2'b11: burst_mask = 5'h1f;
    endcase
  endfunction

  // x16 word lives on the outer lanes; half picks the array half
  function automatic logic [31:0] half_merge(input logic [31:0] buf_v, input logic [31:0] d,
                                             input logic half);
    logic [31:0] r;
    r = buf_v;
    if (half) begin
      r[23:8] = buf_v[23:8] & {d[31:24], d[7:0]};
    end else begin
      r[7:0] = buf_v[7:0] & d[7:0];
      r[31:24] = buf_v[31:24] & d[31:24];
    end
    half_merge = r;
  endfunction

  localparam logic [11:0] PROG_CYCLES = 12'(`SFCE_PROG_CYCLES);
  localparam logic [11:0] ERASE_CYCLES = 12'(`SFCE_ERASE_CYCLES);

  sfce_state_t s_q;
  sfce_state_t s_d;

  logic x16;
  logic busy;
  logic rd_addr_phase;
  logic advance;
  logic [17:0] lin_addr;
  logic [17:0] eff_addr;
  logic [4:0] mask;
  logic [4:0] boff_next;
  logic [1:0] a10;
  logic sync_wr;
  logic async_wr;
  logic wr_event;
  logic [17:0] wr_addr;
  logic [31:0] wr_data;
  logic [7:0] cmd;
  logic all_ones;
  logic [31:0] rd_word;
  logic [31:0] lane_mask;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  always_comb begin
    x16 = s_q.device_config_reg[`SFCE_DCR_WORD_PIN] & ~word_mode_in;
    busy = (s_q.write_state_machine != SFCE_WSM_IDLE);
    mask = burst_mask(s_q.device_config_reg[`SFCE_DCR_BURST_LSB +: 2]);
    lin_addr = x16 ? {addr_in, addr_half_in} : {1'b0, addr_in};
    // read address phase: address taken, read select high
    rd_addr_phase = ~strobes_in.chip_enable_n & ~strobes_in.load_burst_address_n
                    & strobes_in.write_read_select_n;
    // advance freezes while either strobe is high (burst suspend)
    advance = ~strobes_in.chip_enable_n & strobes_in.load_burst_address_n
              & ~strobes_in.burst_advance_n & ~strobes_in.output_enable_n;
    boff_next = (s_q.boff + 5'h01) & mask;
    if (rd_addr_phase) begin
      // held-low latch re-reads the live address each clock
      eff_addr = lin_addr;
    end else begin
      eff_addr = (s_q.rbase & ~{13'h0000, mask})
                 | ({13'h0000, (s_q.rbase[4:0] + (advance ? boff_next : s_q.boff)) & mask});
    end
    a10 = x16 ? eff_addr[2:1] : eff_addr[1:0];
    // writes: synchronous strobe on the clock, or asynchronous strobe edge
    sync_wr = ~strobes_in.chip_enable_n & ~strobes_in.write_enable_n;
    async_wr = ~s_q.strobe_prev & strobes_in.write_strobe_n & ~strobes_in.chip_enable_n;
    wr_event = (sync_wr | async_wr) & reset_powerdown_n_in;
    wr_addr = (async_wr | ~strobes_in.load_burst_address_n) ? lin_addr : s_q.rbase;
    wr_data = dq_in;
    cmd = wr_data[7:0];
    all_ones = x16 ? ({wr_data[31:24], wr_data[7:0]} == 16'hffff) : (wr_data == 32'hffff_ffff);
    lane_mask = x16 ? 32'hff00_00ff : 32'hffff_ffff;
    array_rd_addr_out = busy ? s_q.waddr : eff_addr;
  end

  // ----------------------------------------
  // read data source
  // ----------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    if (busy || s_q.st == SFCE_ST_READ_STATUS) begin
      // only status is answered while the algorithm runs
      rd_word = {24'h00_0000, s_q.status};
    end else if (s_q.st == SFCE_ST_READ_ID) begin
      unique case (a10)
        2'b00: rd_word = {24'h00_0000, `SFCE_MAKER_ID};
        2'b01: rd_word = {24'h00_0000, `SFCE_PART_ID};
        2'b10: rd_word = s_q.device_config_reg;
        2'b11: rd_word = 32'h0000_0000;
      endcase
    end else begin
      rd_word = array_rdata_in;
      if (x16 && eff_addr[0]) begin
        // upper array half folds onto the x16 lanes
        rd_word = {array_rdata_in[23:16], 16'h0000, array_rdata_in[15:8]};
      end
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.req.prog = 1'b0;
    s_d.req.erase = 1'b0;
    s_d.strobe_prev = strobes_in.write_strobe_n;

    // ---------- read path ----------
    if (rd_addr_phase) begin
      s_d.rbase = lin_addr;
      s_d.boff = 5'h00;
    end else if (advance) begin
      s_d.boff = boff_next;
    end
    // data registered on the edge that sees enable low, valid next cycle
    if (~strobes_in.chip_enable_n && ~strobes_in.output_enable_n) begin
      s_d.dq = rd_word;
      s_d.dq_oe = lane_mask;
      s_d.drive = 1'b1;
    end else begin
      s_d.dq_oe = 32'h0000_0000;
      s_d.drive = 1'b0;
    end

    // ---------- write state machine ----------
    if (busy) begin
      if (~vpp_ok_in) begin
        s_d.wfail_supply = 1'b1;
      end
      // regulator monitor only when the select bit is clear
      if (~regulator_low_n_in && ~s_q.device_config_reg[`SFCE_DCR_LRV_SELECT]) begin
        s_d.wfail_reg = 1'b1;
      end
      if (s_q.wcnt == 12'h001) begin
        s_d.write_state_machine = SFCE_WSM_IDLE;
        s_d.req.addr = s_q.waddr;
        s_d.req.overlay = s_q.overlay;
        if (!(s_d.wfail_supply || s_d.wfail_reg)) begin
          s_d.req.prog = (s_q.write_state_machine == SFCE_WSM_PROG);
          s_d.req.erase = (s_q.write_state_machine == SFCE_WSM_ERASE);
          // ones in the buffer keep the cell as it is
          s_d.req.wdata = array_rdata_in & s_q.pbuf;
        end
        if (s_d.wfail_supply) begin
          s_d.f3 = 1'b1;
        end
        if (s_q.device_config_reg[`SFCE_DCR_LRV_SELECT]) begin
          if (s_d.wfail_supply && s_q.write_state_machine == SFCE_WSM_PROG) begin
            s_d.f4 = 1'b1;
          end
          if (s_d.wfail_supply && s_q.write_state_machine == SFCE_WSM_ERASE) begin
            s_d.f5 = 1'b1;
          end
        end else begin
          if (s_d.wfail_reg) begin
            s_d.f4 = 1'b1;
          end
          if (s_d.wfail_supply || s_d.wfail_reg) begin
            s_d.f5 = 1'b1;
          end
        end
      end else begin
        s_d.wcnt = s_q.wcnt - 12'h001;
      end
    end

    // ---------- command decoder ----------
    // writes are refused while the algorithm runs
    if (wr_event && !busy) begin
      s_d.psave = 1'b0;
      unique case (s_q.st)
        SFCE_ST_CFG_ARM: begin
          s_d.device_config_reg = wr_data & `SFCE_DCR_LOAD_MASK;
          s_d.st = SFCE_ST_READ_ARRAY;
        end
        SFCE_ST_PROG_SETUP, SFCE_ST_PROG_SECOND: begin
          if (s_q.st == SFCE_ST_PROG_SETUP && all_ones) begin
            s_d.st = SFCE_ST_READ_STATUS;
          end else begin
            s_d.waddr = wr_addr;
            s_d.pbuf = x16 ? half_merge(s_q.pbuf, wr_data, wr_addr[0]) : wr_data;
            if (s_q.st == SFCE_ST_PROG_SETUP && x16 && s_q.device_config_reg[`SFCE_DCR_WORD_WRITE]) begin
              s_d.st = SFCE_ST_PROG_SECOND;
            end else begin
              s_d.st = SFCE_ST_READ_STATUS;
              s_d.write_state_machine = SFCE_WSM_PROG;
              s_d.wcnt = PROG_CYCLES;
              s_d.wfail_supply = 1'b0;
              s_d.wfail_reg = 1'b0;
            end
          end
        end
        SFCE_ST_ERASE_SETUP: begin
          s_d.st = SFCE_ST_READ_STATUS;
          if ((s_q.overlay && cmd == `SFCE_CMD_CONFIRM_OVERLAY)
              || (!s_q.overlay && cmd == `SFCE_CMD_CONFIRM_MAIN)) begin
            // any address inside the block picks it
            s_d.waddr = wr_addr;
            s_d.pbuf = 32'hffff_ffff;
            s_d.write_state_machine = SFCE_WSM_ERASE;
            s_d.wcnt = ERASE_CYCLES;
            s_d.wfail_supply = 1'b0;
            s_d.wfail_reg = 1'b0;
          end else begin
            // bad confirm reads back as a sequence error
            s_d.f4 = 1'b1;
            s_d.f5 = 1'b1;
          end
        end
        default: begin
          s_d.pbuf = 32'hffff_ffff;
          if (cmd == `SFCE_CMD_READ_ARRAY) begin
            s_d.st = SFCE_ST_READ_ARRAY;
          end else if (cmd == `SFCE_CMD_READ_ID) begin
            s_d.st = SFCE_ST_READ_ID;
          end else if (cmd == `SFCE_CMD_READ_STATUS) begin
            s_d.st = SFCE_ST_READ_STATUS;
          end else if (cmd == `SFCE_CMD_CLEAR_STATUS) begin
            s_d.f3 = 1'b0;
            s_d.f4 = 1'b0;
            s_d.f5 = 1'b0;
            s_d.st = SFCE_ST_READ_ARRAY;
          end else if (cmd == `SFCE_CMD_LOAD_CONFIG) begin
            s_d.st = SFCE_ST_CFG_ARM;
          end else if (cmd == `SFCE_CMD_PROG_MAIN || cmd == `SFCE_CMD_PROG_OVERLAY) begin
            s_d.st = SFCE_ST_PROG_SETUP;
            s_d.overlay = (cmd == `SFCE_CMD_PROG_OVERLAY);
          end else if (cmd == `SFCE_CMD_ERASE_MAIN || cmd == `SFCE_CMD_ERASE_OVERLAY) begin
            s_d.st = SFCE_ST_ERASE_SETUP;
            s_d.overlay = (cmd == `SFCE_CMD_ERASE_OVERLAY);
          end else if (cmd == `SFCE_CMD_REDUCED_POWER) begin
            s_d.psave = 1'b1;
          end
        end
      endcase
    end

    // status snapshot refreshed on every clock
    s_d.status = 8'h00;
    s_d.status[`SFCE_SB_READY] = (s_d.write_state_machine == SFCE_WSM_IDLE);
    s_d.status[`SFCE_SB_SUPPLY] = s_d.f3;
    s_d.status[`SFCE_SB_FOUR] = s_d.f4;
    s_d.status[`SFCE_SB_FIVE] = s_d.f5;

    // deep power-down kills everything but the configuration
    if (!reset_powerdown_n_in) begin
      s_d = '0;
      s_d.st = SFCE_ST_READ_ARRAY;
      s_d.write_state_machine = SFCE_WSM_IDLE;
      s_d.pbuf = 32'hffff_ffff;
      s_d.device_config_reg = s_q.device_config_reg;
      s_d.status = 8'h80;
      s_d.strobe_prev = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s_q <= '0;
      s_q.st <= SFCE_ST_READ_ARRAY;
      s_q.write_state_machine <= SFCE_WSM_IDLE;
      s_q.pbuf <= 32'hffff_ffff;
      s_q.device_config_reg <= `SFCE_DCR_RESET;
      s_q.status <= 8'h80;
      s_q.strobe_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign dq_out = s_q.dq;
  assign dq_oe_out = s_q.dq_oe;
  assign output_valid_n_out = ~s_q.drive;
  assign ready_busy_pin_out = s_q.status[`SFCE_SB_READY];
  assign reduced_power_out = s_q.psave;
  assign array_req_out = s_q.req;

endmodule // sfce_top

`default_nettype wire

// *** sfce_map.svh ***
`ifndef SFCE_MAP_SVH
`define SFCE_MAP_SVH

// ----------------------------------------
// command codes (low data byte)
// ----------------------------------------
`define SFCE_CMD_READ_ARRAY 8'hff
`define SFCE_CMD_READ_ID 8'h90
`define SFCE_CMD_READ_STATUS 8'h70
`define SFCE_CMD_CLEAR_STATUS 8'h50
`define SFCE_CMD_LOAD_CONFIG 8'h96
`define SFCE_CMD_PROG_MAIN 8'h40
`define SFCE_CMD_PROG_OVERLAY 8'h04
`define SFCE_CMD_ERASE_MAIN 8'h20
`define SFCE_CMD_ERASE_OVERLAY 8'h02
`define SFCE_CMD_CONFIRM_MAIN 8'hd0
`define SFCE_CMD_CONFIRM_OVERLAY 8'h0d
`define SFCE_CMD_REDUCED_POWER 8'hf0

// ----------------------------------------
// status register bit positions
// ----------------------------------------
`define SFCE_SB_SUPPLY 3
`define SFCE_SB_FOUR 4
`define SFCE_SB_FIVE 5
`define SFCE_SB_READY 7

// ----------------------------------------
// device_config_reg fields and reset value
// ----------------------------------------
`define SFCE_DCR_BURST_LSB 0
`define SFCE_DCR_WORD_PIN 3
`define SFCE_DCR_LRV_SELECT 4
`define SFCE_DCR_WORD_WRITE 31
`define SFCE_DCR_LOAD_MASK 32'hf300_00ff
`define SFCE_DCR_RESET 32'h0000_0000

// ----------------------------------------
// identity codes, values arbitrary
// ----------------------------------------
`define SFCE_MAKER_ID 8'h5a
`define SFCE_PART_ID 8'ha5

// ----------------------------------------
// timing
// ----------------------------------------
`define SFCE_CLK_PERIOD_NS 20
`define SFCE_PROG_TIME_NS 8000
`define SFCE_ERASE_TIME_NS 80000
`define SFCE_PROG_CYCLES ((`SFCE_PROG_TIME_NS + `SFCE_CLK_PERIOD_NS - 1) / `SFCE_CLK_PERIOD_NS)
`define SFCE_ERASE_CYCLES ((`SFCE_ERASE_TIME_NS + `SFCE_CLK_PERIOD_NS - 1) / `SFCE_CLK_PERIOD_NS)

`endif

// *** sfce_pkg.sv ***
package sfce_pkg;

  typedef enum logic [2:0] {
    SFCE_ST_READ_ARRAY = 3'b000,
    SFCE_ST_READ_ID = 3'b001,
    SFCE_ST_READ_STATUS = 3'b010,
    SFCE_ST_CFG_ARM = 3'b011,
    SFCE_ST_PROG_SETUP = 3'b100,
    SFCE_ST_PROG_SECOND = 3'b101,
    SFCE_ST_ERASE_SETUP = 3'b110
  } sfce_cmd_state_t;

  typedef enum logic [1:0] {
    SFCE_WSM_IDLE = 2'b00,
    SFCE_WSM_PROG = 2'b01,
    SFCE_WSM_ERASE = 2'b10
  } sfce_wsm_t;

  // request towards the cell array
  typedef struct packed {
    logic [17:0] addr;
    logic [31:0] wdata;
    logic prog;
    logic erase;
    logic overlay;
  } sfce_array_req_t;

  // host bus strobes, all active low
  typedef struct packed {
    logic chip_enable_n;
    logic load_burst_address_n;
    logic burst_advance_n;
    logic write_read_select_n;
    logic write_enable_n;
    logic write_strobe_n;
    logic output_enable_n;
  } sfce_strobes_t;

  typedef struct packed {
    sfce_cmd_state_t st;
    sfce_wsm_t write_state_machine;
    logic [11:0] wcnt;
    logic wfail_supply;
    logic wfail_reg;
    logic [17:0] waddr;
    logic [31:0] pbuf;
    logic overlay;
    logic f3;
    logic f4;
    logic f5;
    logic [31:0] device_config_reg;
    logic [17:0] rbase;
    logic [4:0] boff;
    logic [31:0] dq;
    logic [31:0] dq_oe;
    logic drive;
    logic [7:0] status;
    logic strobe_prev;
    logic psave;
    sfce_array_req_t req;
  } sfce_state_t;

endpackage

// *** sfce_top_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// port checker, one clock domain
// ----------------------------------------
module sfce_top_sva
  import sfce_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic reset_powerdown_n_in,
  input wire sfce_strobes_t strobes_in,
  input wire logic [31:0] dq_in,
  input wire logic [31:0] dq_out,
  input wire logic [31:0] dq_oe_out,
  input wire logic output_valid_n_out,
  input wire logic ready_busy_pin_out,
  input wire logic reduced_power_out,
  input wire sfce_array_req_t array_req_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);
  logic rd_e;
  logic wr_e;
  assign rd_e = !strobes_in.chip_enable_n && !strobes_in.output_enable_n && reset_powerdown_n_in;
  assign wr_e = !strobes_in.chip_enable_n && !strobes_in.write_enable_n && reset_powerdown_n_in;
  a_read_answer: assert property (rd_e |=> !output_valid_n_out &&
    dq_oe_out inside {32'hffff_ffff, 32'hff00_00ff})
    else $error("read edge not answered");
  a_valid_idle: assert property (!rd_e |=> output_valid_n_out && dq_oe_out == 32'h0)
    else $error("data driven without read");
  a_busy_status: assert property (!ready_busy_pin_out && !$past(ready_busy_pin_out) &&
    !output_valid_n_out |-> dq_out[7] == 1'b0 && dq_out[6] == 1'b0 && dq_out[2:0] == 3'h0)
    else $error("busy read not status");
  a_op_ends: assert property (array_req_out.prog || array_req_out.erase |=> ready_busy_pin_out &&
    !array_req_out.prog && !array_req_out.erase)
    else $error("op end wrong");
  a_no_stray: assert property (array_req_out.prog || array_req_out.erase |->
    !$past(ready_busy_pin_out))
    else $error("array op without busy run");
  a_busy_cause: assert property ($fell(ready_busy_pin_out) |-> $past(wr_e) ||
    ($past(strobes_in.write_strobe_n) && !$past(strobes_in.write_strobe_n, 2)))
    else $error("busy without write");
  a_rp_abort: assert property (!reset_powerdown_n_in ##1 !reset_powerdown_n_in |=>
    ready_busy_pin_out && !array_req_out.prog && !array_req_out.erase)
    else $error("power-down did not abort");
  a_rst_state: assert property ($fell(reset_in) |-> ready_busy_pin_out && output_valid_n_out &&
    !reduced_power_out && dq_oe_out == 32'h0)
    else $error("reset state wrong");
  a_power_back: assert property (reduced_power_out && ready_busy_pin_out && wr_e &&
    dq_in[7:0] != 8'hf0 |=> !reduced_power_out)
    else $error("full power not restored");
endmodule // sfce_top_sva
bind sfce_top sfce_top_sva sfce_top_sva_i (
  .clk_sys_in, .reset_in, .reset_powerdown_n_in, .strobes_in, .dq_in, .dq_out, .dq_oe_out,
  .output_valid_n_out, .ready_busy_pin_out, .reduced_power_out, .array_req_out
);
`default_nettype wire

// *** sfce_array_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// cell array on the far side
// ----------------------------------------
module sfce_array_model
  import sfce_pkg::*;
#(
  parameter int BLOCK_LSB = 12
)
(
  input wire logic clk_sys_in,
  input wire logic [17:0] rd_addr_in,
  input wire sfce_array_req_t req_in,
  output logic [31:0] rdata_out,
  output logic last_overlay_out
);
  // sparse store, unwritten words read as erased
  logic [31:0] mem [logic [18:0]];
  logic [18:0] kill_q [$];
  int unsigned ver = 0;
  always @(rd_addr_in, ver) begin
    rdata_out = mem.exists({1'b0, rd_addr_in}) ? mem[{1'b0, rd_addr_in}] : 32'hffff_ffff;
  end
  always @(posedge clk_sys_in) begin
    if (req_in.prog) begin
      mem[{req_in.overlay, req_in.addr}] = req_in.wdata;
    end
    if (req_in.erase) begin
      kill_q = {};
      foreach (mem[k]) begin
        if (k[18] == req_in.overlay && k[17:BLOCK_LSB] == req_in.addr[17:BLOCK_LSB]) begin
          kill_q.push_back(k);
        end
      end
      foreach (kill_q[i]) begin
        mem.delete(kill_q[i]);
      end
    end
    if (req_in.prog || req_in.erase) begin
      last_overlay_out <= req_in.overlay;
      ver <= ver + 1;
    end
  end
endmodule // sfce_array_model
`default_nettype wire

// *** tb_sync_flash_command_engine.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_sync_flash_command_engine
  import sfce_pkg::*;
;
  logic clk_sys_in;
  logic reset_in;
  logic reset_powerdown_n_in;
  sfce_strobes_t strobes_in;
  logic [16:0] addr_in;
  logic [31:0] dq_in;
  logic vpp_ok_in;
  logic regulator_low_n_in;
  logic [31:0] dq_out;
  logic [31:0] dq_oe_out;
  logic output_valid_n_out;
  logic ready_busy_pin_out;
  logic reduced_power_out;
  logic [17:0] array_rd_addr_out;
  logic [31:0] array_rdata_in;
  sfce_array_req_t array_req_out;
  logic ovl;
  int n_mismatch;
  int checked;
  logic [31:0] seed;
  logic [31:0] got [$];
  logic [31:0] exp_m [logic [16:0]];
  // x32 only: width pin and half select tied, x16 left to later
  sfce_top sfce_top_i (
    .clk_sys_in, .reset_in, .reset_powerdown_n_in, .strobes_in, .addr_in, .addr_half_in(1'b0),
    .word_mode_in(1'b1), .vpp_ok_in, .regulator_low_n_in, .dq_in, .dq_out, .dq_oe_out,
    .output_valid_n_out, .ready_busy_pin_out, .reduced_power_out, .array_rd_addr_out,
    .array_rdata_in, .array_req_out
  );
  sfce_array_model sfce_array_model_i (
    .clk_sys_in, .rd_addr_in(array_rd_addr_out), .req_in(array_req_out),
    .rdata_out(array_rdata_in), .last_overlay_out(ovl)
  );
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  // ----------------------------------------
  // helpers; strobes: ce lba baa wr we ws oe
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] ev(input logic [16:0] a);
    return exp_m.exists(a) ? exp_m[a] : 32'hffff_ffff;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [31:0] v, input logic [16:0] a);
    @(posedge clk_sys_in);
    strobes_in <= 7'h13;
    addr_in <= a;
    dq_in <= v;
    @(posedge clk_sys_in);
    strobes_in <= 7'h7f;
  endtask
  // strobe rise taken with chip enable still low
  task automatic aw(input logic [31:0] v, input logic [16:0] a);
    @(posedge clk_sys_in);
    strobes_in <= 7'h3d;
    addr_in <= a;
    dq_in <= v;
    @(posedge clk_sys_in);
    strobes_in <= 7'h3f;
    @(posedge clk_sys_in);
    strobes_in <= 7'h7f;
  endtask
  task automatic rd(input logic [16:0] a, input int n, input bit asy);
    got = {};
    @(posedge clk_sys_in);
    strobes_in <= asy ? 7'h1e : 7'h1f;
    addr_in <= a;
    if (!asy) begin
      @(posedge clk_sys_in);
      strobes_in <= 7'h3e;
    end
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_in);
      strobes_in <= (i < n - 1) ? 7'h2e : 7'h7f;
      #1 got.push_back(dq_out);
    end
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    #1;
    while (ready_busy_pin_out !== 1'b1 && k < 5000) begin
      @(posedge clk_sys_in);
      k++;
    end
    if (k >= 5000) begin
      n_mismatch++;
      $display("Error at %0t: busy never ended", $time);
    end
    // array model takes the end pulse one edge after ready rises
    @(posedge clk_sys_in);
    #1;
  endtask
  task automatic prog(input logic [7:0] c, input logic [16:0] a, input logic [31:0] v);
    wr({24'h0, c}, 17'h0);
    wr(v, a);
    #1 chk(32'(ready_busy_pin_out), 32'h0);
    rd(a, 1, 1'b0);
    chk(32'(got[0][7]), 32'h0);
    wait_ready();
  endtask
  task automatic status_is(input logic [7:0] e);
    wr(32'h70, 17'h0);
    rd(17'h0, 1, 1'b0);
    chk(32'(got[0][7:0]), {24'h0, e});
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [16:0] base;
    logic [16:0] a;
    logic [31:0] v;
    logic [1:0] s;
    logic [7:0] id_t [3];
    logic [7:0] fail_t [3];
    id_t = '{8'h5a, 8'ha5, 8'h00};
    fail_t = '{8'ha8, 8'hb0, 8'h98};
    n_mismatch = 0;
    checked = 0;
    seed = 32'h54cc3f54;
    strobes_in = 7'h7f;
    addr_in = 17'h0;
    dq_in = 32'h0;
    vpp_ok_in = 1'b1;
    regulator_low_n_in = 1'b1;
    reset_powerdown_n_in = 1'b1;
    reset_in = 1'b1;
    repeat (12) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    status_is(8'h80);
    wr(32'h90, 17'h0);
    for (int i = 0; i < 3; i++) begin
      rd(17'(i), 1, 1'b0);
      chk(32'(got[0][7:0]), {24'h0, id_t[i]});
    end
    base = 17'(rnd() & 32'h1fffc);
    for (int i = 0; i < 6; i++) begin
      a = base + 17'(i % 4);
      v = rnd() & 32'h7fff_ffff;
      prog(8'h40, a, v);
      exp_m[a] = ev(a) & v;
      chk(32'(ovl), 32'h0);
    end
    wr(32'hff, 17'h0);
    s = 2'(rnd());
    rd(base + 17'(s), 4, 1'b0);
    for (int j = 0; j < 4; j++) begin
      chk(got[j], ev({base[16:2], 2'(s + j)}));
    end
    wr(32'h40, 17'h0);
    wr(32'hffff_ffff, base + 17'h2);
    wait_ready();
    wr(32'hff, 17'h0);
    rd(base + 17'h2, 1, 1'b0);
    chk(got[0], ev(base + 17'h2));
    for (int k = 0; k < 3; k++) begin
      if (k == 2) begin
        wr(32'h96, 17'h0);
        wr(32'h0000_0010, 17'h0);
        wr(32'h90, 17'h0);
        rd(17'h2, 1, 1'b0);
        chk(32'(got[0][7:0]), 32'h10);
      end
      vpp_ok_in <= (k == 1);
      regulator_low_n_in <= (k != 1);
      prog(8'h40, base + 17'h3, rnd() & 32'h7fff_ffff);
      vpp_ok_in <= 1'b1;
      regulator_low_n_in <= 1'b1;
      status_is(fail_t[k]);
      wr(32'h50, 17'h0);
      rd(base + 17'h3, 1, 1'b0);
      chk(got[0], ev(base + 17'h3));
      status_is(8'h80);
    end
    wr(32'hf0, 17'h0);
    #1 chk(32'(reduced_power_out), 32'h1);
    wr(32'h90, 17'h0);
    #1 chk(32'(reduced_power_out), 32'h0);
    aw(32'h70, 17'h0);
    rd(17'h1, 1, 1'b1);
    chk(32'(got[0][7:0]), 32'h80);
    prog(8'h04, base, 32'h0);
    chk(32'(ovl), 32'h1);
    wr(32'h02, 17'h0);
    wr(32'h0d, base);
    wait_ready();
    chk(32'(ovl), 32'h1);
    wr(32'h20, 17'h0);
    wr(32'hd0, base);
    repeat (100) @(posedge clk_sys_in);
    reset_powerdown_n_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    reset_powerdown_n_in <= 1'b1;
    #1 chk(32'(ready_busy_pin_out), 32'h1);
    rd(base, 1, 1'b0);
    chk(got[0], ev(base));
    wr(32'h20, 17'h0);
    wr(32'hd0, base + 17'h1);
    wait_ready();
    wr(32'hff, 17'h0);
    rd(base, 4, 1'b0);
    for (int j = 0; j < 4; j++) begin
      chk(got[j], 32'hffff_ffff);
    end
    chk(32'(ovl), 32'h0);
    summarize();
  end
  // bounded well above the two erases and ten programs
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    n_mismatch++;
    $display("Error at %0t: run hung", $time);
    summarize();
  end
endmodule // tb_sync_flash_command_engine
`default_nettype wire
